/* File: hw/tsa_map.vh */
`ifndef TSA_MAP_VH
`define TSA_MAP_VH

// ----------------------------------------------------------------------
// register pointer codes
// ----------------------------------------------------------------------
`define TSA_PTR_TEMP 2'h0
`define TSA_PTR_SETUP 2'h1
`define TSA_PTR_LOWER 2'h2
`define TSA_PTR_UPPER 2'h3

// ----------------------------------------------------------------------
// setup word field positions
// ----------------------------------------------------------------------
`define TSA_TRIP_BIT 5
`define TSA_RATE_LSB 6
`define TSA_RATE_MSB 7
`define TSA_SLEEP_BIT 8
`define TSA_STYLE_BIT 9
`define TSA_LEVEL_BIT 10
`define TSA_FAULT_LSB 11
`define TSA_FAULT_MSB 12
`define TSA_FIXED13_BIT 13
`define TSA_FIXED14_BIT 14
`define TSA_SHOT_BIT 15

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TSA_RATE_RESET 2'h2
`define TSA_FIXED14_VALUE 1'h1
`define TSA_TEMP_RESET 16'h0000
`define TSA_LOWER_RESET 16'h2580
`define TSA_UPPER_RESET 16'h2800
`define TSA_THRESH_MASK 16'hfff0

// ----------------------------------------------------------------------
// timing: one tick per 125 ms, interval in ticks per rate code
// ----------------------------------------------------------------------
`define TSA_CLK_KHZ 125000
`define TSA_TICK_MS 125
`define TSA_TICK_CYCLES (`TSA_TICK_MS * `TSA_CLK_KHZ)
`define TSA_IVL_RATE0 6'h20
`define TSA_IVL_RATE1 6'h08
`define TSA_IVL_RATE2 6'h02
`define TSA_IVL_RATE3 6'h01

`endif

/* File: hw/tsa_twi_slave.v */
`timescale 1ns/1ps
module tsa_twi_slave
(
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n_out,
  // device address
  input wire [6:0] dev_addr_in,
  // byte side
  input wire [7:0] rd_byte_in,
  output reg start_out,
  output reg wr_out,
  output reg wr_first_out,
  output reg [7:0] wr_data_out,
  output reg rd_taken_out
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_WR = 2'h2;
  localparam ST_RD = 2'h3;

  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg scl_d;
  reg sda_d;
  reg [1:0] state;
  reg [3:0] cnt;
  reg [7:0] shift;
  reg rw;
  reg first;
  reg nack;

  wire scl_rise = scl_sync[1] & ~scl_d;
  wire scl_fall = ~scl_sync[1] & scl_d;
  wire bus_start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  wire bus_stop = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // ----------------------------------------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  // ----------------------------------------------------------------------
  // byte engine: sample on rising scl, drive on falling scl
  // ----------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    start_out <= 1'h0;
    wr_out <= 1'h0;
    rd_taken_out <= 1'h0;
    sda_out <= 1'h0;
    if (!rst_n_in)
    begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      rw <= 1'h0;
      first <= 1'h0;
      nack <= 1'h0;
      sda_oe_n_out <= 1'h1;
      wr_first_out <= 1'h0;
      wr_data_out <= 8'h00;
    end
    else if (bus_start)
    begin
      state <= ST_ADDR;
      cnt <= 4'h0;
      first <= 1'h1;
      sda_oe_n_out <= 1'h1;
      start_out <= 1'h1;
    end
    else if (bus_stop)
    begin
      state <= ST_IDLE;
      sda_oe_n_out <= 1'h1;
    end
    else if (state != ST_IDLE && scl_rise)
    begin
      cnt <= cnt + 4'h1;
      if (cnt < 4'h8)
        shift <= (state == ST_RD) ? shift : {shift[6:0], sda_sync[1]};
      else
        nack <= sda_sync[1];
    end
    else if (state != ST_IDLE && scl_fall)
    begin
      case (state)
        ST_ADDR:
        begin
          if (cnt == 4'h8)
          begin
            if (shift[7:1] == dev_addr_in)
            begin
              rw <= shift[0];
              sda_oe_n_out <= 1'h0;
            end
            else
              state <= ST_IDLE;
          end
          else if (cnt == 4'h9)
          begin
            cnt <= 4'h0;
            state <= rw ? ST_RD : ST_WR;
            sda_oe_n_out <= rw ? rd_byte_in[7] : 1'h1;
            shift <= rd_byte_in;
            rd_taken_out <= rw;
          end
        end
        ST_WR:
        begin
          if (cnt == 4'h8)
          begin
            wr_out <= 1'h1;
            wr_first_out <= first;
            wr_data_out <= shift;
            first <= 1'h0;
            sda_oe_n_out <= 1'h0;
          end
          else if (cnt == 4'h9)
          begin
            cnt <= 4'h0;
            sda_oe_n_out <= 1'h1;
          end
        end
        ST_RD:
        begin
          if (cnt >= 4'h1 && cnt <= 4'h7)
          begin
            sda_oe_n_out <= shift[6];
            shift <= {shift[6:0], 1'h0};
          end
          else if (cnt == 4'h8)
            sda_oe_n_out <= 1'h1;
          else if (cnt == 4'h9)
          begin
            cnt <= 4'h0;
            // a nack from the host ends the read burst
            if (nack)
              state <= ST_IDLE;
            else
            begin
              shift <= rd_byte_in;
              sda_oe_n_out <= rd_byte_in[7];
              rd_taken_out <= 1'h1;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule // tsa_twi_slave

/* File: hw/tsa_core.v */
`timescale 1ns/1ps
`include "tsa_map.vh"

// Notes on behaviour
// R1: the two low pointer bits route each access to one of four registers
// R2: pointer keeps only two writable bits; upper bits are zero and ignored
// R3: measured temperature is read-only; setup and thresholds read and write
// R4: every 16-bit register moves upper byte first, then lower byte
// R5: setup bits 0-4 and 13-14 ignore writes; all zero except bit 14
// R6: setup layout: trip, rate, sleep, style, level, fault count, one-shot
// R7: trip flag flips on N upper faults and back on N lower faults
// R8: active level sets the active polarity of trip flag and alert pin
// R9: in comparator style the trip flag equals the alert pin state
// R10: rate field picks 0.25, 1, 4 or 8 conversions per second
// R11: measured temperature changes only when a conversion completes
// R12: a conversion starts right after reset without any host command
// R13: standby between conversions until the rate timer starts the next
// R14: sleep select stops conversions after the current one completes; registers stay accessible
// R15: host pairs one-shot with sleep entry; sleep settles within 150 ms
// R16: clearing sleep select resumes periodic conversions at the set rate
// R17: style 0 is comparator behaviour, style 1 interrupt behaviour
// R18: comparator alert holds from upper crossing until lower crossing
// R19: interrupt alert fires on each crossing of upper or lower threshold
// R20: interrupt alert clears on any read or sleep entry, then re-arms
// R21: upper test is inclusive: equal to the threshold counts as fault
// R22: alert needs N consecutive faulting conversions, N is code plus one
// R23: one-shot in sleep runs one conversion, reads 1 until it finishes
// R24: host must not re-trigger one-shots so fast that the die self-heats
// R25: a rate change reloads the interval timer to the new interval
module tsa_core
#(
  parameter TICK_CYCLES = `TSA_TICK_CYCLES
)
(
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // two-wire bus pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n_out,
  input wire [6:0] dev_addr_in,
  // converter handshake
  output reg conv_start_out,
  input wire conv_done_in,
  input wire [15:0] conv_result_in,
  output reg standby_out,
  // alert pin
  output reg alert_out,
  output reg alert_oe_n_out
);

  reg [1:0] pointer;
  reg [15:0] measured_temp;
  reg [15:0] lower_threshold;
  reg [15:0] upper_threshold;
  reg [1:0] conversion_rate;
  reg sleep_select;
  reg pulse_style_select;
  reg active_level;
  reg [1:0] fault_count;
  reg shot_busy;
  reg byte_sel;
  reg [7:0] msb_hold;
  reg [7:0] shadow_lo;
  reg [7:0] rd_byte;
  reg busy;
  reg first_pending;
  reg due;
  reg [31:0] tick_cnt;
  reg [5:0] ivl_cnt;
  reg [2:0] hi_run;
  reg [2:0] lo_run;
  reg cmp_active;
  reg int_active;
  reg arm_high;

  wire start_pulse;
  wire wr_pulse;
  wire wr_first;
  wire [7:0] wr_data;
  wire rd_taken;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function [5:0] ivl_of;
    input [1:0] rate;
    begin
      case (rate)
        2'h0: ivl_of = `TSA_IVL_RATE0;
        2'h1: ivl_of = `TSA_IVL_RATE1;
        2'h2: ivl_of = `TSA_IVL_RATE2;
        default: ivl_of = `TSA_IVL_RATE3;
      endcase
    end
  endfunction

  function [2:0] run_next;
    input hit;
    input [2:0] run;
    begin
      if (!hit)
        run_next = 3'h0;
      else if (run == 3'h4)
        run_next = run;
      else
        run_next = run + 3'h1;
    end
  endfunction

  // polarity 0 reads 1 while inactive
  wire trip_flag = active_level ? cmp_active : ~cmp_active; // R7 R8 R9

  wire [15:0] setup_word = {shot_busy, `TSA_FIXED14_VALUE, 1'h0,
                            fault_count, active_level, pulse_style_select,
                            sleep_select, conversion_rate, trip_flag,
                            5'h00}; // R5 R6

  reg [15:0] sel_word;
  always @*
  begin
    case (pointer) // R1
      `TSA_PTR_TEMP: sel_word = measured_temp;
      `TSA_PTR_SETUP: sel_word = setup_word;
      `TSA_PTR_LOWER: sel_word = lower_threshold;
      default: sel_word = upper_threshold;
    endcase
  end

  // ----------------------------------------------------------------------
  // bus byte engine
  // ----------------------------------------------------------------------
  tsa_twi_slave u_twi
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out),
    .dev_addr_in(dev_addr_in),
    .rd_byte_in(rd_byte),
    .start_out(start_pulse),
    .wr_out(wr_pulse),
    .wr_first_out(wr_first),
    .wr_data_out(wr_data),
    .rd_taken_out(rd_taken)
  );

  wire [15:0] wr_word = {msb_hold, wr_data};
  wire commit = wr_pulse & ~wr_first & byte_sel;
  wire setup_wr = commit & (pointer == `TSA_PTR_SETUP);
  wire sleep_entry = setup_wr & wr_word[`TSA_SLEEP_BIT] & ~sleep_select;
  wire sleep_exit = setup_wr & ~wr_word[`TSA_SLEEP_BIT] & sleep_select;
  wire rate_change = setup_wr &
    (wr_word[`TSA_RATE_MSB:`TSA_RATE_LSB] != conversion_rate);

  // ----------------------------------------------------------------------
  // pointer, byte pairing and register writes
  // ----------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      pointer <= 2'h0;
      byte_sel <= 1'h0;
      msb_hold <= 8'h00;
      shadow_lo <= 8'h00;
      rd_byte <= 8'h00;
      lower_threshold <= `TSA_LOWER_RESET;
      upper_threshold <= `TSA_UPPER_RESET;
      conversion_rate <= `TSA_RATE_RESET;
      sleep_select <= 1'h0;
      pulse_style_select <= 1'h0;
      active_level <= 1'h0;
      fault_count <= 2'h0;
    end
    else
    begin
      // upper byte always goes first; a snapshot keeps the pair coherent
      rd_byte <= byte_sel ? shadow_lo : sel_word[15:8]; // R4
      if (start_pulse)
        byte_sel <= 1'h0;
      else if (rd_taken)
      begin
        byte_sel <= ~byte_sel;
        if (!byte_sel)
          shadow_lo <= sel_word[7:0];
      end
      else if (wr_pulse && wr_first)
        pointer <= wr_data[1:0]; // R2
      else if (wr_pulse && !byte_sel)
      begin
        msb_hold <= wr_data; // R4
        byte_sel <= 1'h1;
      end
      else if (wr_pulse)
      begin
        byte_sel <= 1'h0;
        case (pointer) // R3
          `TSA_PTR_SETUP:
          begin
            conversion_rate <= wr_word[`TSA_RATE_MSB:`TSA_RATE_LSB]; // R10
            sleep_select <= wr_word[`TSA_SLEEP_BIT]; // R14 R16
            pulse_style_select <= wr_word[`TSA_STYLE_BIT]; // R17
            active_level <= wr_word[`TSA_LEVEL_BIT]; // R8
            fault_count <= wr_word[`TSA_FAULT_MSB:`TSA_FAULT_LSB]; // R22
          end
          `TSA_PTR_LOWER:
            lower_threshold <= wr_word & `TSA_THRESH_MASK;
          `TSA_PTR_UPPER:
            upper_threshold <= wr_word & `TSA_THRESH_MASK;
          default:
            pointer <= pointer;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // conversion scheduling
  // ----------------------------------------------------------------------
  wire tick = (tick_cnt == TICK_CYCLES - 1);
  wire ivl_end = tick & (ivl_cnt + 6'h1 >= ivl_of(conversion_rate));
  wire want = sleep_select ? shot_busy : (first_pending | due);
  wire go = want & ~busy & ~conv_start_out;

  always @(posedge clk_in)
  begin
    conv_start_out <= 1'h0;
    if (!rst_n_in)
    begin
      tick_cnt <= 32'h0;
      ivl_cnt <= 6'h00;
      first_pending <= 1'h1; // R12
      due <= 1'h0;
      busy <= 1'h0;
      shot_busy <= 1'h0;
      standby_out <= 1'h1;
      measured_temp <= `TSA_TEMP_RESET;
    end
    else
    begin
      // timer held at zero while asleep; reloaded on rate change or wake
      if (sleep_select || rate_change || sleep_exit)
      begin
        tick_cnt <= 32'h0; // R25
        ivl_cnt <= 6'h00;
      end
      else if (tick)
      begin
        tick_cnt <= 32'h0;
        ivl_cnt <= ivl_end ? 6'h00 : ivl_cnt + 6'h1; // R10
      end
      else
        tick_cnt <= tick_cnt + 32'h1;
      if (sleep_entry)
      begin
        due <= 1'h0; // R14
        first_pending <= 1'h0;
      end
      else if (sleep_exit)
        due <= 1'h1; // R16
      else if (ivl_end && !sleep_select)
        due <= 1'h1; // R13
      else if (go)
      begin
        due <= 1'h0;
        first_pending <= 1'h0;
      end
      // one-shot only takes effect with sleep set in the same word
      if (setup_wr && wr_word[`TSA_SHOT_BIT] && wr_word[`TSA_SLEEP_BIT])
        shot_busy <= 1'h1; // R15 R23
      else if (conv_done_in && busy && sleep_select)
        shot_busy <= 1'h0; // R23
      else if (!sleep_select && setup_wr)
        shot_busy <= 1'h0;
      if (go)
      begin
        conv_start_out <= 1'h1;
        busy <= 1'h1;
        standby_out <= 1'h0;
      end
      else if (conv_done_in && busy)
      begin
        busy <= 1'h0;
        standby_out <= 1'h1; // R13
        measured_temp <= conv_result_in; // R11
      end
    end
  end

  // ----------------------------------------------------------------------
  // threshold and alert logic
  // ----------------------------------------------------------------------
  wire [2:0] need = {1'h0, fault_count} + 3'h1; // R22
  wire hit_hi = $signed(conv_result_in) >= $signed(upper_threshold); // R21
  wire hit_lo = $signed(conv_result_in) <= $signed(lower_threshold);
  wire [2:0] next_hi_run = run_next(hit_hi, hi_run);
  wire [2:0] next_lo_run = run_next(hit_lo, lo_run);
  wire done = conv_done_in & busy;
  wire pin_act = pulse_style_select ? int_active : cmp_active; // R17

  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      hi_run <= 3'h0;
      lo_run <= 3'h0;
      cmp_active <= 1'h0;
      int_active <= 1'h0;
      arm_high <= 1'h1;
      alert_out <= 1'h0;
      alert_oe_n_out <= 1'h1;
    end
    else
    begin
      alert_out <= 1'h0;
      // open drain: pull low only when the pin level is 0
      alert_oe_n_out <= active_level ? pin_act : ~pin_act; // R8 R9
      if (done)
      begin
        hi_run <= next_hi_run; // R22
        lo_run <= next_lo_run;
        if (!cmp_active && next_hi_run >= need)
          cmp_active <= 1'h1; // R18
        else if (cmp_active && next_lo_run >= need)
          cmp_active <= 1'h0; // R18
      end
      if (!pulse_style_select)
      begin
        int_active <= 1'h0;
        arm_high <= 1'h1;
      end
      else if (done && arm_high && next_hi_run >= need)
      begin
        int_active <= 1'h1; // R19
        arm_high <= 1'h0; // R20
      end
      else if (done && !arm_high && next_lo_run >= need)
      begin
        int_active <= 1'h1; // R19
        arm_high <= 1'h1; // R20
      end
      else if (rd_taken || sleep_entry)
        int_active <= 1'h0; // R20
    end
  end

endmodule // tsa_core

/* File: verification/tsa_checker.sv */
`timescale 1ns/1ps
module tsa_checker
#(
  parameter TICK_CYCLES = 50
)
(
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // bus pins
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n_out,
  input wire [6:0] dev_addr_in,
  // converter
  input wire conv_start_out,
  input wire conv_done_in,
  input wire [15:0] conv_result_in,
  input wire standby_out,
  // alert pin
  input wire alert_out,
  input wire alert_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // cycles since the bus clock last moved
  // ----------------------------------------
  reg [3:0] scl_quiet;
  reg scl_prev;
  always @(posedge clk_in)
  begin
    scl_prev <= scl_in;
    if (!rst_n_in || scl_in != scl_prev)
      scl_quiet <= 4'h0;
    else if (scl_quiet != 4'hf)
      scl_quiet <= scl_quiet + 4'h1;
  end
  sequence run_begin;
    ##1 (!conv_start_out && !standby_out);
  endsequence
  por_start_a: assert property ($rose(rst_n_in) |=> conv_start_out)
    else $error("no conversion after reset");
  start_run_a: assert property (conv_start_out |-> run_begin)
    else $error("start did not leave standby");
  conv_end_a: assert property (conv_done_in && !standby_out |=> standby_out)
    else $error("standby not resumed after done");
  standby_exit_a: assert property ($fell(standby_out) |-> conv_start_out)
    else $error("standby left without a start");
  busy_start_a: assert property (!standby_out |=> !conv_start_out)
    else $error("start while converting");
  // alert moves only after a result or bus traffic, never on its own
  alert_cause_a: assert property ($changed(alert_oe_n_out) |->
    $past(conv_done_in, 2) || $past(conv_done_in, 3) || scl_quiet < 4'hc)
    else $error("alert changed without cause");
  sda_phase_a: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("data moved while bus clock high");
  alert_low_a: assert property (!alert_oe_n_out |-> !alert_out)
    else $error("alert pin driven high");
endmodule // tsa_checker

bind tsa_core tsa_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk
(
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out),
  .dev_addr_in(dev_addr_in),
  .conv_start_out(conv_start_out),
  .conv_done_in(conv_done_in),
  .conv_result_in(conv_result_in),
  .standby_out(standby_out),
  .alert_out(alert_out),
  .alert_oe_n_out(alert_oe_n_out)
);

/* File: verification/tsa_host.sv */
`timescale 1ns/1ps
module tsa_host
#(
  parameter HALF_NS = 80,
  parameter [6:0] ADDR = 7'h48
)
(
  // bus wires
  input wire sda_in,
  output reg scl_out,
  output reg sda_out
);
  integer nacks;
  reg s;
  integer k;
  initial
  begin
    nacks = 0;
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task bus_start;
  begin
    sda_out = 1'b1;
    #HALF_NS scl_out = 1'b1;
    #HALF_NS sda_out = 1'b0;
    #HALF_NS scl_out = 1'b0;
  end
  endtask
  task bus_stop;
  begin
    sda_out = 1'b0;
    #HALF_NS scl_out = 1'b1;
    #HALF_NS sda_out = 1'b1;
    #HALF_NS;
  end
  endtask
  // sample mid-high, well after the device's delayed data change
  task bus_bit(input b, output v);
  begin
    sda_out = b;
    #HALF_NS scl_out = 1'b1;
    #(HALF_NS / 2) v = sda_in;
    #(HALF_NS / 2) scl_out = 1'b0;
  end
  endtask
  task put_byte(input [7:0] d);
  begin
    for (k = 7; k >= 0; k = k - 1)
      bus_bit(d[k], s);
    bus_bit(1'b1, s);
    if (s !== 1'b0)
      nacks = nacks + 1;
  end
  endtask
  task get_byte(input last, output [7:0] d);
  begin
    for (k = 7; k >= 0; k = k - 1)
      bus_bit(1'b1, d[k]);
    bus_bit(last, s);
  end
  endtask
  task write_word(input [7:0] ptr, input [15:0] v);
  begin
    bus_start;
    put_byte({ADDR, 1'b0});
    put_byte(ptr);
    put_byte(v[15:8]);
    put_byte(v[7:0]);
    bus_stop;
  end
  endtask
  task read_word(input [7:0] ptr, output [15:0] v);
  begin
    bus_start;
    put_byte({ADDR, 1'b0});
    put_byte(ptr);
    bus_start;
    put_byte({ADDR, 1'b1});
    get_byte(1'b0, v[15:8]);
    get_byte(1'b1, v[7:0]);
    bus_stop;
  end
  endtask
endmodule // tsa_host

/* File: verification/temp_sensor_config_alert_tb.sv */
`timescale 1ns/1ps
module temp_sensor_config_alert_tb;
  localparam TICK = 50;
  localparam LIMIT = 80000;
  reg clk_in, rst_n_in, conv_done_in, slow, done_now;
  reg [15:0] conv_result_in, temp_now, temp_q, got;
  reg [31:0] seed;
  integer errors, checks, cycles, nstart, left, i, n;
  wire scl_w, h_sda, sda_out, sda_oe_n_out, conv_start_out;
  wire standby_out, alert_out, alert_oe_n_out;
  wire sda_w = h_sda & (sda_oe_n_out | sda_out);
  reg [15:0] expq[$];
  event got_ev;
  tsa_core #(.TICK_CYCLES(TICK)) i_dut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .dev_addr_in(7'h48), .conv_start_out(conv_start_out),
    .conv_done_in(conv_done_in), .conv_result_in(conv_result_in),
    .standby_out(standby_out), .alert_out(alert_out),
    .alert_oe_n_out(alert_oe_n_out));
  tsa_host #(.ADDR(7'h48)) i_host (.sda_in(sda_w), .scl_out(scl_w),
    .sda_out(h_sda));
  function [31:0] rnd(input [31:0] v);
    reg [31:0] x;
  begin
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    rnd = x ^ (x << 5);
  end
  endfunction
  task conclude;
  begin
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task chk(input string what, input [31:0] seen, input [31:0] want);
  begin
    checks = checks + 1;
    if (seen !== want)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  end
  endtask
  // ----------------------------------------
  // converter stand-in: random latency, junk data outside done
  // ----------------------------------------
  always @(negedge clk_in)
  begin
    seed = rnd(seed);
    done_now = 1'b0;
    if (conv_start_out)
    begin
      nstart = nstart + 1;
      left = slow ? 1500 : 3 + seed[3:0];
    end
    else if (left > 0)
    begin
      left = left - 1;
      done_now = (left == 0);
    end
    conv_done_in <= done_now;
    conv_result_in <= done_now ? temp_q : seed[15:0];
  end
  // temperature reaches the converter one rising edge late, so a change
  // made at a falling edge never races a result taken at that edge
  always @(posedge clk_in)
    temp_q <= temp_now;
  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == LIMIT)
    begin
      errors = errors + 1;
      conclude;
    end
  end
  always @(got_ev)
    chk("reg word", got, expq.pop_front());
  task rd(input [7:0] ptr, input [15:0] want);
  begin
    expq.push_back(want);
    i_host.read_word(ptr, got);
    -> got_ev;
  end
  endtask
  task wr(input [7:0] ptr, input [15:0] v);
    i_host.write_word(ptr, v);
  endtask
  task settle(input integer cnt);
  begin
    // a result seen at the first edge still carries the old temperature
    @(posedge clk_in);
    repeat (cnt)
    begin
      @(posedge clk_in);
      while (!conv_done_in) @(posedge clk_in);
    end
    repeat (6) @(negedge clk_in);
  end
  endtask
  task gap(input integer want);
    integer c;
  begin
    c = 1;
    @(negedge clk_in);
    while (!conv_start_out) @(negedge clk_in);
    @(negedge clk_in);
    while (!conv_start_out)
    begin
      c = c + 1;
      @(negedge clk_in);
    end
    chk("interval", c, want);
  end
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial
  begin
    errors = 0;
    checks = 0;
    cycles = 0;
    nstart = 0;
    left = 0;
    slow = 1'b0;
    seed = 32'h53fe;
    temp_now = 16'h1800;
    rst_n_in = 1'b0;
    conv_done_in = 1'b0;
    conv_result_in = 16'h0000;
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    rd(8'h01, 16'h40a0);
    rd(8'h02, 16'h2580);
    rd(8'h03, 16'h2800);
    wr(8'h01, 16'h60df);
    rd(8'h01, 16'h40e0);
    wr(8'hfe, 16'h1237);
    rd(8'hfe, 16'h1230);
    // comparator style, two faults, active low
    wr(8'h02, 16'h1000);
    wr(8'h03, 16'h2000);
    wr(8'h01, 16'h08c0);
    temp_now = 16'h2000;
    settle(1);
    chk("alert pin", alert_oe_n_out, 1'b1);
    settle(1);
    chk("alert pin", alert_oe_n_out, 1'b0);
    rd(8'h01, 16'h48c0);
    temp_now = 16'h0ff0;
    settle(1);
    chk("alert pin", alert_oe_n_out, 1'b0);
    settle(1);
    chk("alert pin", alert_oe_n_out, 1'b1);
    wr(8'h01, 16'h0cc0);
    rd(8'h01, 16'h4cc0);
    chk("alert pin", alert_oe_n_out, 1'b0);
    temp_now = 16'h2000;
    settle(2);
    chk("alert pin", alert_oe_n_out, 1'b1);
    temp_now = 16'h0ff0;
    settle(2);
    // four faults to raise, then three to drop
    wr(8'h01, 16'h18c0);
    temp_now = 16'h2000;
    settle(3);
    chk("alert pin", alert_oe_n_out, 1'b1);
    settle(1);
    chk("alert pin", alert_oe_n_out, 1'b0);
    wr(8'h01, 16'h10c0);
    temp_now = 16'h0ff0;
    settle(2);
    chk("alert pin", alert_oe_n_out, 1'b0);
    settle(1);
    chk("alert pin", alert_oe_n_out, 1'b1);
    // interrupt style, one fault
    temp_now = 16'h1800;
    wr(8'h01, 16'h02c0);
    temp_now = 16'h2000;
    settle(1);
    chk("alert pin", alert_oe_n_out, 1'b0);
    settle(2);
    chk("alert pin", alert_oe_n_out, 1'b0);
    rd(8'h03, 16'h2000);
    chk("alert pin", alert_oe_n_out, 1'b1);
    temp_now = 16'h0ff0;
    settle(1);
    chk("alert pin", alert_oe_n_out, 1'b0);
    // slow rate first so no periodic start overlaps the sleep entry
    wr(8'h01, 16'h0200);
    slow = 1'b1;
    wr(8'h01, 16'h8300);
    chk("alert pin", alert_oe_n_out, 1'b1);
    rd(8'h01, 16'hc320);
    settle(1);
    slow = 1'b0;
    n = nstart;
    temp_now = 16'h1111;
    wr(8'h00, 16'h1234);
    rd(8'h00, 16'h0ff0);
    rd(8'h01, 16'h4320);
    chk("starts", nstart - n, 0);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h01, {8'h00, i[1:0], 6'h00});
      gap(TICK * (i == 3 ? 1 : 32 >> (2 * i)));
    end
    chk("host nacks", i_host.nacks, 0);
    conclude;
  end
endmodule // temp_sensor_config_alert_tb
